// [src/pppc_defines.svh]
`ifndef PPPC_DEFINES_SVH
`define PPPC_DEFINES_SVH

// host command code and reset image of the option register
`define PPPC_CMD_CODE          8'h31
`define PPPC_OPT_RESET         16'h00B7
// bits the host stores; the two cycle status bits are hardware-owned
`define PPPC_HOST_RW_MASK      16'hF3FF

// field positions inside the option register
`define PPPC_DEG_MSB           15
`define PPPC_DEG_LSB           14
`define PPPC_TRIG_IIN_BIT      13
`define PPPC_TRIG_VSYS_BIT     12
`define PPPC_OVLD_BIT          11
`define PPPC_RELAX_BIT         10
`define PPPC_TMAX_MSB          9
`define PPPC_TMAX_LSB          8
`define PPPC_EXT_LIMIT_BIT     7
`define PPPC_MON_DIR_BIT       6
`define PPPC_LSW_OCP_BIT       5
`define PPPC_FIXED_OCP_BIT     4
`define PPPC_ACOC_EN_BIT       3
`define PPPC_ACOC_RATIO_BIT    2
`define PPPC_BATOC_EN_BIT      1
`define PPPC_BATOC_RATIO_BIT   0

// clock rate used to turn times into cycle counts
`define PPPC_CLK_MHZ           50
`define PPPC_US_PER_MS         1000
`define PPPC_US_PER_S          1000000

// overload deglitch times per select code
`define PPPC_DEG_SEL0_MS       1
`define PPPC_DEG_SEL1_MS       2
`define PPPC_DEG_SEL2_MS       5
`define PPPC_DEG_SEL3_MS       10
// overload and relax cycle times per select code
`define PPPC_TMAX_SEL0_MS      20
`define PPPC_TMAX_SEL1_MS      40
`define PPPC_TMAX_SEL2_MS      80
`define PPPC_TMAX_SEL3_S       1
// configurable input overcurrent blank-out and restart deglitch
`define PPPC_BLANK_US          250
`define PPPC_RESTART_MS        250

// switch and fixed input overcurrent thresholds in mV
`define PPPC_LSW_THR0_MV       10'h0D2
`define PPPC_LSW_THR1_MV       10'h096
`define PPPC_FIX_THR00_MV      10'h118
`define PPPC_FIX_THR01_MV      10'h0C8
`define PPPC_FIX_THR10_MV      10'h096
`define PPPC_FIX_THR11_MV      10'h064
// overcurrent ratios in percent of the reference level
`define PPPC_RATIO_LOW_PCT     133
`define PPPC_RATIO_HIGH_PCT    200
`define PPPC_PCT_BASE          100

`endif

// [src/pppc_pkg.sv]
package pppc_pkg;

    // peak power sequencer states
    typedef enum logic [1:0] {
        peak_idle,
        peak_overload,
        peak_relax
    } pppc_peak_state_type;

endpackage : pppc_pkg

// [src/pppc_cycle_timer.sv]
`timescale 1ns/1ns

module pppc_cycle_timer
    import pppc_pkg::*;
#(
    parameter int TW = 26
) (
    input  logic          clk,
    input  logic          rst_b,
    input  logic          ce,
    input  logic          start,
    input  logic          stop,
    input  logic [TW-1:0] length,
    output logic          expired
);

    logic [TW-1:0] cnt_ff;

    // start wins over stop so a new cycle is never dropped
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= '0;
        end else if (ce) begin
            if (start) begin
                cnt_ff <= length;
            end else if (stop) begin
                cnt_ff <= '0;
            end else if (cnt_ff != '0) begin
                cnt_ff <= cnt_ff - TW'(1);
            end
        end
    end

    // last cycle of the loaded length; kept free of start and stop
    // so the sequencer sees no combinational loop
    assign expired = ce && (cnt_ff == TW'(1));

endmodule : pppc_cycle_timer

// [src/pppc_deglitch.sv]
`timescale 1ns/1ns

module pppc_deglitch
    import pppc_pkg::*;
#(
    parameter int TW = 26
) (
    input  logic          clk,
    input  logic          rst_b,
    input  logic          ce,
    input  logic          raw,
    input  logic [TW-1:0] rise_cycles,
    input  logic [TW-1:0] fall_cycles,
    output logic          filtered_ff
);

    logic [TW-1:0] cnt_ff;
    logic [TW-1:0] target;
    logic [TW-1:0] cnt_inc;

    // separate rise and fall delays; a zero delay acts as one cycle
    assign target  = raw ? rise_cycles : fall_cycles;
    assign cnt_inc = cnt_ff + TW'(1);

    // any bounce back to the filtered level restarts the count
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            filtered_ff <= 1'b0;
            cnt_ff      <= '0;
        end else if (ce) begin
            if (raw == filtered_ff) begin
                cnt_ff <= '0;
            end else if (cnt_inc >= target) begin
                filtered_ff <= raw;
                cnt_ff      <= '0;
            end else begin
                cnt_ff <= cnt_inc;
            end
        end
    end

endmodule : pppc_deglitch

// [src/pppc_options.sv]
`timescale 1ns/1ns
`include "pppc_defines.svh"

module pppc_options
    import pppc_pkg::*;
#(
    parameter int CW          = 8,
    parameter int TW          = 26,
    parameter int DEG_CYC_0   = `PPPC_DEG_SEL0_MS * `PPPC_US_PER_MS
                                * `PPPC_CLK_MHZ,
    parameter int DEG_CYC_1   = `PPPC_DEG_SEL1_MS * `PPPC_US_PER_MS
                                * `PPPC_CLK_MHZ,
    parameter int DEG_CYC_2   = `PPPC_DEG_SEL2_MS * `PPPC_US_PER_MS
                                * `PPPC_CLK_MHZ,
    parameter int DEG_CYC_3   = `PPPC_DEG_SEL3_MS * `PPPC_US_PER_MS
                                * `PPPC_CLK_MHZ,
    parameter int TMAX_CYC_0  = `PPPC_TMAX_SEL0_MS * `PPPC_US_PER_MS
                                * `PPPC_CLK_MHZ,
    parameter int TMAX_CYC_1  = `PPPC_TMAX_SEL1_MS * `PPPC_US_PER_MS
                                * `PPPC_CLK_MHZ,
    parameter int TMAX_CYC_2  = `PPPC_TMAX_SEL2_MS * `PPPC_US_PER_MS
                                * `PPPC_CLK_MHZ,
    parameter int TMAX_CYC_3  = `PPPC_TMAX_SEL3_S * `PPPC_US_PER_S
                                * `PPPC_CLK_MHZ,
    parameter int BLANK_CYC   = `PPPC_BLANK_US * `PPPC_CLK_MHZ,
    parameter int RESTART_CYC = `PPPC_RESTART_MS * `PPPC_US_PER_MS
                                * `PPPC_CLK_MHZ
) (
    input  logic          clk,
    input  logic          rst_b,
    input  logic          ce,
    input  logic          cmd_write,
    input  logic          cmd_read,
    input  logic [7:0]    cmd_code,
    input  logic [15:0]   cmd_wdata,
    output logic [15:0]   cmd_rdata_ff,
    output logic          cmd_rvalid_ff,
    input  logic          adapter_present,
    input  logic          input_overshoot,
    input  logic          system_undershoot,
    input  logic [CW-1:0] input_limit_register,
    input  logic [CW-1:0] external_limit_pin,
    output logic [CW-1:0] input_limit_eff_ff,
    input  logic [CW-1:0] charge_current,
    input  logic [CW-1:0] discharge_current,
    output logic [CW-1:0] battery_current_monitor_out_ff,
    input  logic [9:0]    low_switch_vds_mv,
    input  logic [9:0]    input_sense_mv,
    input  logic          input_sense_resistor_select,
    input  logic [CW-1:0] input_current,
    input  logic [CW-1:0] second_input_limit_level,
    input  logic [CW-1:0] second_discharge_threshold,
    output logic          low_switch_overcurrent_ff,
    output logic          converter_enable_ff,
    output logic          overload_cycle_flag_ff,
    output logic          relax_cycle_flag_ff
);

    // pick one of four cycle counts by a two-bit select code
    function automatic logic [TW-1:0] pick4(
        input logic [1:0] sel,
        input int         c0,
        input int         c1,
        input int         c2,
        input int         c3
    );
        case (sel)
            2'h0:    return TW'(c0);
            2'h1:    return TW'(c1);
            2'h2:    return TW'(c2);
            default: return TW'(c3);
        endcase
    endfunction : pick4

    // percentage of a reference level; two extra bits hold 200%
    function automatic logic [CW+1:0] ratio_thr(
        input logic [CW-1:0] level,
        input logic          high_sel
    );
        logic [CW+7:0] wide;
        logic [CW+7:0] pct;
        wide = {8'h00, level};
        pct  = high_sel ? (CW+8)'(`PPPC_RATIO_HIGH_PCT)
                        : (CW+8)'(`PPPC_RATIO_LOW_PCT);
        wide = (wide * pct) / (CW+8)'(`PPPC_PCT_BASE);
        return wide[CW+1:0];
    endfunction : ratio_thr

    pppc_peak_state_type state_ff;
    pppc_peak_state_type nxt_state;
    logic [15:0]         opt_ff;
    logic [15:0]         nxt_opt;
    logic [15:0]         read_word;
    logic                wr_hit;
    logic                rd_hit;
    logic                any_en;
    logic                trig_raw;
    logic                trig_ok;
    logic                cyc_start;
    logic                cyc_stop;
    logic                cyc_done;
    logic                host_exit_ovl;
    logic                host_exit_rlx;
    logic [TW-1:0]       deg_cyc;
    logic [TW-1:0]       tmax_cyc;
    logic [CW-1:0]       nxt_limit;
    logic [9:0]          lsw_thr;
    logic [9:0]          fixed_thr;
    logic                fixed_trip;
    logic [CW+1:0]       acoc_thr;
    logic                acoc_raw;
    logic                acoc_filt;
    logic                acoc_off;
    logic [CW+1:0]       batoc_thr;
    logic                batoc_trip;
    logic [9:0]          wdata_low;

    // command decode; other command codes belong to other registers
    assign wr_hit    = cmd_write && (cmd_code == `PPPC_CMD_CODE);
    assign rd_hit    = cmd_read && (cmd_code == `PPPC_CMD_CODE);
    assign wdata_low = cmd_wdata[9:0];

    // host image of the options; adapter removal overrides a host set
    always_comb begin
        nxt_opt = opt_ff;
        if (wr_hit) begin
            nxt_opt = cmd_wdata & `PPPC_HOST_RW_MASK;
        end
        if (!adapter_present) begin
            nxt_opt[`PPPC_TRIG_IIN_BIT]  = 1'b0;
            nxt_opt[`PPPC_TRIG_VSYS_BIT] = 1'b0;
        end
    end

    // option storage, reset image gives all documented defaults
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            opt_ff <= `PPPC_OPT_RESET;
        end else if (ce) begin
            opt_ff <= nxt_opt;
        end
    end

    // read image merges the live cycle flags into the status bits
    always_comb begin
        read_word                 = opt_ff;
        read_word[`PPPC_OVLD_BIT]  = overload_cycle_flag_ff;
        read_word[`PPPC_RELAX_BIT] = relax_cycle_flag_ff;
    end

    // read answer one cycle after the request, valid for one cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_rdata_ff  <= 16'h0000;
            cmd_rvalid_ff <= 1'b0;
        end else if (ce) begin
            cmd_rvalid_ff <= rd_hit;
            if (rd_hit) begin
                cmd_rdata_ff <= read_word;
            end
        end
    end

    // trigger sources, each gated by its own enable bit
    assign any_en   = opt_ff[`PPPC_TRIG_IIN_BIT] ||
                      opt_ff[`PPPC_TRIG_VSYS_BIT];
    assign trig_raw = (opt_ff[`PPPC_TRIG_IIN_BIT] && input_overshoot) ||
                      (opt_ff[`PPPC_TRIG_VSYS_BIT] && system_undershoot);
    assign deg_cyc  = pick4(opt_ff[`PPPC_DEG_MSB:`PPPC_DEG_LSB],
                            DEG_CYC_0, DEG_CYC_1,
                            DEG_CYC_2, DEG_CYC_3);
    assign tmax_cyc = pick4(opt_ff[`PPPC_TMAX_MSB:`PPPC_TMAX_LSB],
                            TMAX_CYC_0, TMAX_CYC_1,
                            TMAX_CYC_2, TMAX_CYC_3);

    // overload must persist for the deglitch time; release is immediate
    pppc_deglitch #(
        .TW          (TW)
    ) u_trig_deglitch (
        .clk         (clk),
        .rst_b       (rst_b),
        .ce          (ce),
        .raw         (trig_raw),
        .rise_cycles (deg_cyc),
        .fall_cycles (TW'(1)),
        .filtered_ff (trig_ok)
    );

    // one timer shared by overload and relax cycles
    pppc_cycle_timer #(
        .TW      (TW)
    ) u_cycle_timer (
        .clk     (clk),
        .rst_b   (rst_b),
        .ce      (ce),
        .start   (cyc_start),
        .stop    (cyc_stop),
        .length  (tmax_cyc),
        .expired (cyc_done)
    );

    assign host_exit_ovl = wr_hit && !cmd_wdata[`PPPC_OVLD_BIT];
    assign host_exit_rlx = wr_hit && !cmd_wdata[`PPPC_RELAX_BIT];
    assign cyc_stop      = (nxt_state == peak_idle);

    // sequencer: cycle expiry is checked before the host exit so that
    // entry into the next cycle wins over a clear in the same cycle
    always_comb begin
        nxt_state = state_ff;
        cyc_start = 1'b0;
        case (state_ff)
            peak_idle: begin
                if (trig_ok) begin
                    nxt_state = peak_overload;
                    cyc_start = 1'b1;
                end
            end
            peak_overload: begin
                if (cyc_done) begin
                    nxt_state = peak_relax;
                    cyc_start = 1'b1;
                end else if (host_exit_ovl) begin
                    nxt_state = peak_idle;
                end
            end
            peak_relax: begin
                if (cyc_done && trig_ok) begin
                    nxt_state = peak_overload;
                    cyc_start = 1'b1;
                end else if (cyc_done || host_exit_rlx) begin
                    nxt_state = peak_idle;
                end
            end
            default: begin
                nxt_state = peak_idle;
            end
        endcase
        if (!any_en) begin
            nxt_state = peak_idle;
            cyc_start = 1'b0;
        end
    end

    // state and its flags move together
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff               <= peak_idle;
            overload_cycle_flag_ff <= 1'b0;
            relax_cycle_flag_ff    <= 1'b0;
        end else if (ce) begin
            state_ff               <= nxt_state;
            overload_cycle_flag_ff <= (nxt_state == peak_overload);
            relax_cycle_flag_ff    <= (nxt_state == peak_relax);
        end
    end

    // input limit source and monitor direction
    assign nxt_limit = (opt_ff[`PPPC_EXT_LIMIT_BIT] &&
                        (external_limit_pin < input_limit_register))
                       ? external_limit_pin : input_limit_register;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            input_limit_eff_ff             <= '0;
            battery_current_monitor_out_ff <= '0;
        end else if (ce) begin
            input_limit_eff_ff             <= nxt_limit;
            battery_current_monitor_out_ff <= opt_ff[`PPPC_MON_DIR_BIT]
                ? charge_current : discharge_current;
        end
    end

    // overcurrent thresholds; the fixed one also follows sense resistor
    assign lsw_thr = opt_ff[`PPPC_LSW_OCP_BIT] ? `PPPC_LSW_THR1_MV
                                               : `PPPC_LSW_THR0_MV;
    always_comb begin
        case ({opt_ff[`PPPC_FIXED_OCP_BIT], input_sense_resistor_select})
            2'h0:    fixed_thr = `PPPC_FIX_THR00_MV;
            2'h1:    fixed_thr = `PPPC_FIX_THR01_MV;
            2'h2:    fixed_thr = `PPPC_FIX_THR10_MV;
            default: fixed_thr = `PPPC_FIX_THR11_MV;
        endcase
    end
    assign fixed_trip = input_sense_mv > fixed_thr;
    assign acoc_thr   = ratio_thr(second_input_limit_level,
                                  opt_ff[`PPPC_ACOC_RATIO_BIT]);
    assign acoc_raw   = opt_ff[`PPPC_ACOC_EN_BIT] &&
                        ({2'b00, input_current} > acoc_thr);
    assign batoc_thr  = ratio_thr(second_discharge_threshold,
                                  opt_ff[`PPPC_BATOC_RATIO_BIT]);
    assign batoc_trip = opt_ff[`PPPC_BATOC_EN_BIT] &&
                        ({2'b00, discharge_current} > batoc_thr);

    // blank-out on the way in, long deglitch on the way out
    pppc_deglitch #(
        .TW          (TW)
    ) u_acoc_deglitch (
        .clk         (clk),
        .rst_b       (rst_b),
        .ce          (ce),
        .raw         (acoc_raw),
        .rise_cycles (TW'(BLANK_CYC)),
        .fall_cycles (TW'(RESTART_CYC)),
        .filtered_ff (acoc_filt)
    );
    // clearing the enable releases the converter without the long wait
    assign acoc_off = opt_ff[`PPPC_ACOC_EN_BIT] && acoc_filt;

    // none of the faults latch: the enable follows the comparators
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            low_switch_overcurrent_ff <= 1'b0;
            converter_enable_ff       <= 1'b0;
        end else if (ce) begin
            low_switch_overcurrent_ff <= low_switch_vds_mv > lsw_thr;
            converter_enable_ff <= !(fixed_trip || acoc_off ||
                                     batoc_trip);
        end
    end

    property p_off_when_disabled;
        @(posedge clk) disable iff (!rst_b)
        (ce && !any_en) |=> (state_ff == peak_idle);
    endproperty
    a_off_when_disabled: assert property (p_off_when_disabled)
        else $error("peak mode left active with both triggers off");

    property p_adapter_clear;
        @(posedge clk) disable iff (!rst_b)
        (ce && !adapter_present) |=>
            !opt_ff[`PPPC_TRIG_IIN_BIT] && !opt_ff[`PPPC_TRIG_VSYS_BIT];
    endproperty
    a_adapter_clear: assert property (p_adapter_clear)
        else $error("trigger enables kept after adapter removal");

    property p_enter_overload;
        @(posedge clk) disable iff (!rst_b)
        (ce && state_ff == peak_idle && any_en && trig_ok) |=>
            overload_cycle_flag_ff && !relax_cycle_flag_ff;
    endproperty
    a_enter_overload: assert property (p_enter_overload)
        else $error("no overload entry on qualified trigger");

    property p_host_exit_ovl;
        @(posedge clk) disable iff (!rst_b)
        (ce && overload_cycle_flag_ff && host_exit_ovl) |=>
            !overload_cycle_flag_ff;
    endproperty
    a_host_exit_ovl: assert property (p_host_exit_ovl)
        else $error("overload cycle not ended by host write of zero");

    property p_host_exit_rlx;
        @(posedge clk) disable iff (!rst_b)
        (ce && relax_cycle_flag_ff && host_exit_rlx) |=>
            !relax_cycle_flag_ff;
    endproperty
    a_host_exit_rlx: assert property (p_host_exit_rlx)
        else $error("relax cycle not ended by host write of zero");

    property p_alternate;
        @(posedge clk) disable iff (!rst_b)
        (ce && state_ff == peak_overload && cyc_done && any_en) |=>
            relax_cycle_flag_ff && !overload_cycle_flag_ff;
    endproperty
    a_alternate: assert property (p_alternate)
        else $error("overload expiry did not start a relax cycle");

    property p_register_limit;
        @(posedge clk) disable iff (!rst_b)
        (ce && !opt_ff[`PPPC_EXT_LIMIT_BIT]) |=>
            (input_limit_eff_ff == $past(input_limit_register));
    endproperty
    a_register_limit: assert property (p_register_limit)
        else $error("limit not taken from the register alone");

    property p_monitor_charge;
        @(posedge clk) disable iff (!rst_b)
        (ce && opt_ff[`PPPC_MON_DIR_BIT]) |=>
            (battery_current_monitor_out_ff == $past(charge_current));
    endproperty
    a_monitor_charge: assert property (p_monitor_charge)
        else $error("monitor not showing charge current");

    property p_fixed_stop;
        @(posedge clk) disable iff (!rst_b)
        (ce && (fixed_trip || acoc_off)) |=> !converter_enable_ff;
    endproperty
    a_fixed_stop: assert property (p_fixed_stop)
        else $error("converter running during input overcurrent");

    property p_batoc_stop;
        @(posedge clk) disable iff (!rst_b)
        (ce && opt_ff[`PPPC_BATOC_EN_BIT] &&
         ({2'b00, discharge_current} > batoc_thr)) |=> !converter_enable_ff;
    endproperty
    a_batoc_stop: assert property (p_batoc_stop)
        else $error("converter running during discharge overcurrent");

    property p_write_read;
        @(posedge clk) disable iff (!rst_b)
        (ce && wr_hit ##1 ce && rd_hit) |=>
            cmd_rvalid_ff && (cmd_rdata_ff[9:0] == $past(wdata_low, 2));
    endproperty
    a_write_read: assert property (p_write_read)
        else $error("read back differs from the written settings");

endmodule : pppc_options

// [verification/pppc_host_model.sv]
`timescale 1ns/1ns
// host side of the command port: one strobe pulse per word
module pppc_host_model (
    input  logic        clk,
    output logic        cmd_write,
    output logic        cmd_read,
    output logic [7:0]  cmd_code,
    output logic [15:0] cmd_wdata
);
    initial begin
        {cmd_write, cmd_read} = 2'b00;
        {cmd_code, cmd_wdata} = 24'h000000;
    end
    // held across one taking edge; released data is inverted so a
    // stale word is never mistaken for a live one
    task automatic xfer(input logic w, input logic [7:0] c,
                        input logic [15:0] d);
        @(posedge clk);
        #2;
        {cmd_write, cmd_read, cmd_code, cmd_wdata} = {w, !w, c, d};
        @(posedge clk);
        #2;
        {cmd_write, cmd_read, cmd_wdata} = {2'b00, ~d};
    endtask : xfer
    // write and read back on the very next edge, no idle cycle between
    task automatic wr_rd(input logic [15:0] d);
        @(posedge clk);
        #2;
        {cmd_write, cmd_read, cmd_code, cmd_wdata} = {2'b10, 8'h31, d};
        @(posedge clk);
        #2;
        {cmd_write, cmd_read} = 2'b01;
        @(posedge clk);
        #2;
        {cmd_write, cmd_read, cmd_wdata} = {2'b00, ~d};
    endtask : wr_rd
endmodule : pppc_host_model

// [verification/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
    logic        clk, rst_b, ce, cmd_write, cmd_read, cmd_rvalid_ff;
    logic        adapter_present, input_overshoot, system_undershoot;
    logic        input_sense_resistor_select, low_switch_overcurrent_ff;
    logic        converter_enable_ff, overload_cycle_flag_ff;
    logic        relax_cycle_flag_ff;
    logic [7:0]  cmd_code, input_limit_register, external_limit_pin;
    logic [7:0]  input_limit_eff_ff, charge_current, discharge_current;
    logic [7:0]  battery_current_monitor_out_ff, input_current;
    logic [7:0]  second_input_limit_level, second_discharge_threshold;
    logic [9:0]  low_switch_vds_mv, input_sense_mv;
    logic [15:0] cmd_wdata, cmd_rdata_ff, ex;
    logic [31:0] seed;
    logic [15:0] exp_q[$];
    int          miscompares, comparisons, n;

    pppc_options #(.DEG_CYC_0(4), .DEG_CYC_1(8), .DEG_CYC_2(20),
        .DEG_CYC_3(40), .TMAX_CYC_0(40), .TMAX_CYC_1(80),
        .TMAX_CYC_2(160), .TMAX_CYC_3(400), .BLANK_CYC(10),
        .RESTART_CYC(50)) uut (.clk, .rst_b, .ce, .cmd_write,
        .cmd_read, .cmd_code, .cmd_wdata, .cmd_rdata_ff, .cmd_rvalid_ff,
        .adapter_present, .input_overshoot, .system_undershoot,
        .input_limit_register, .external_limit_pin, .input_limit_eff_ff,
        .charge_current, .discharge_current,
        .battery_current_monitor_out_ff, .low_switch_vds_mv,
        .input_sense_mv, .input_sense_resistor_select, .input_current,
        .second_input_limit_level, .second_discharge_threshold,
        .low_switch_overcurrent_ff, .converter_enable_ff,
        .overload_cycle_flag_ff, .relax_cycle_flag_ff);
    pppc_host_model host (.clk, .cmd_write, .cmd_read, .cmd_code,
        .cmd_wdata);

    initial clk = 1'b0;
    always #10 clk = ~clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] s);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic settle(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask : settle

    // derived outputs lag a write by one more edge
    task automatic wrc(input logic [15:0] w, input logic e);
        host.xfer(1'b1, 8'h31, w);
        settle(2);
        chk("converter", e, converter_enable_ff);
    endtask : wrc

    // reads note the word first; a stray answer finds no note and fails
    always @(posedge clk) begin
        if (cmd_rvalid_ff === 1'b1) begin
            ex = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hXXXX;
            chk("read word", ex, cmd_rdata_ff);
        end
    end

    initial begin
        {rst_b, ce} = 2'b01;
        {adapter_present, input_overshoot, system_undershoot} = 3'h4;
        input_sense_resistor_select = 1'b0;
        {input_current, charge_current} = 16'h0000;
        {second_input_limit_level, second_discharge_threshold} = 16'h1010;
        {low_switch_vds_mv, input_sense_mv} = 20'h2D000;
        {input_limit_register, external_limit_pin} = 16'h0000;
        discharge_current = 8'h00;
        seed = 32'h7846;
        repeat (16) @(posedge clk);
        #2;
        rst_b = 1'b1;
        exp_q.push_back(16'h00B7);
        host.xfer(1'b0, 8'h31, 16'h0000);
        exp_q.push_back(16'hF3FF);
        host.wr_rd(16'hFFFF);
        adapter_present = 1'b0;
        exp_q.push_back(16'hC3FF);
        host.xfer(1'b0, 8'h31, 16'h0000);
        adapter_present = 1'b1;
        host.xfer(1'b0, 8'h32, 16'h0000);
        // a write while the enable is low must leave the image alone
        ce = 1'b0;
        host.xfer(1'b1, 8'h31, 16'h0000);
        ce = 1'b1;
        exp_q.push_back(16'hC3FF);
        host.xfer(1'b0, 8'h31, 16'h0000);
        repeat (17) seed = lfsr(seed);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            {charge_current, discharge_current} = seed[15:0];
            {input_limit_register, external_limit_pin} = seed[31:16];
            {low_switch_vds_mv, input_sense_resistor_select,
             system_undershoot} = seed[11:0];
            host.xfer(1'b1, 8'h31, {8'h00, i[0], i[1], i[0], 5'h00});
            settle(2);
            ex = (i[0] && external_limit_pin < input_limit_register)
                 ? external_limit_pin : input_limit_register;
            chk("limit", ex, input_limit_eff_ff);
            ex = i[1] ? charge_current : discharge_current;
            chk("monitor", ex, battery_current_monitor_out_ff);
            ex = low_switch_vds_mv > (i[0] ? 10'h096 : 10'h0D2);
            chk("switch trip", ex, low_switch_overcurrent_ff);
        end
        input_sense_mv = {2'b11, seed[7:0]};
        settle(2);
        chk("converter", 1'b0, converter_enable_ff);
        // 31 lies above 133% and below 200% of any level 16 to 23
        {input_sense_mv, discharge_current} = 18'h0001F;
        second_discharge_threshold = {5'h02, seed[2:0]};
        wrc(16'h0003, 1'b1);
        wrc(16'h0002, 1'b0);
        wrc(16'h0000, 1'b1);
        // level at most 63, so any current of 128 or more trips at 133%
        {second_input_limit_level, input_current} =
            {2'b00, seed[29:24], 1'b1, seed[6:0]};
        host.xfer(1'b1, 8'h31, 16'h0008);
        settle(5);
        chk("blank-out", 1'b1, converter_enable_ff);
        settle(7);
        chk("input overcurrent", 1'b0, converter_enable_ff);
        input_current = 8'h00;
        settle(45);
        chk("restart wait", 1'b0, converter_enable_ff);
        settle(10);
        chk("restart", 1'b1, converter_enable_ff);
        input_overshoot = 1'b1;
        host.xfer(1'b1, 8'h31, 16'h2000);
        for (n = 0; overload_cycle_flag_ff !== 1'b1 && n < 30; n++)
            settle(1);
        for (n = 0; overload_cycle_flag_ff === 1'b1 && n < 500; n++)
            settle(1);
        chk("overload span", 16'h0028, n[15:0]);
        chk("relax entry", 1'b1, relax_cycle_flag_ff);
        // trigger dropped first so the sequencer stays idle after the host write ends the cycle
        input_overshoot = 1'b0;
        host.xfer(1'b1, 8'h31, 16'h2000);
        chk("relax exit", 1'b0, relax_cycle_flag_ff);
        system_undershoot = 1'b1;
        host.xfer(1'b1, 8'h31, 16'h1000);
        for (n = 0; overload_cycle_flag_ff !== 1'b1 && n < 30; n++)
            settle(1);
        chk("undershoot entry", 1'b1, overload_cycle_flag_ff);
        system_undershoot = 1'b0;
        host.xfer(1'b1, 8'h31, 16'h1000);
        chk("overload exit", 1'b0, overload_cycle_flag_ff);
        {input_overshoot, system_undershoot} = 2'b11;
        host.xfer(1'b1, 8'h31, 16'h0000);
        settle(10);
        chk("flags", 2'b00, {overload_cycle_flag_ff,
            relax_cycle_flag_ff});
        end_sim();
    end

    // the sequence needs well under 2000 cycles
    initial begin
        #40000;
        miscompares++;
        end_sim();
    end

    task automatic end_sim();
        $display("comparisons %0d miscompares %0d", comparisons,
                 miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim
endmodule : tb_top
